// ==== hw/msa_pkg.sv ====
// Constants, types and register map of the microstore address sequencer
package msa_pkg;

    // Clock and cycle timing
    localparam int REF_CLK_NS = 50;
    localparam int ROS_CYCLE_NS = 600;
    localparam int CORE_CYCLE_NS = 1800;
    localparam int ROS_CYCLE_CLKS = ROS_CYCLE_NS / REF_CLK_NS;
    localparam int CORE_ROS_CYCLES = CORE_CYCLE_NS / ROS_CYCLE_NS;

    // Phases inside one control-store cycle
    localparam logic [3:0] PH_LAST = 4'(ROS_CYCLE_CLKS - 1);
    localparam logic [3:0] PH_EARLY = 4'h0;
    localparam logic [3:0] PH_DRV_ON = 4'h2;
    localparam logic [3:0] PH_SENSE = 4'h5;
    localparam logic [3:0] PH_DRV_OFF = 4'h8;
    localparam logic [3:0] PH_LATE = 4'h9;

    // Index of each address position inside micro_address_register
    localparam int A_10 = 0;
    localparam int A_11 = 1;
    localparam int A_12 = 2;
    localparam int A_13 = 3;
    localparam int A_14 = 4;
    localparam int A_15 = 5;
    localparam int A_16 = 6;
    localparam int A_17 = 7;
    localparam int A_18 = 8;
    localparam int A_19 = 9;
    localparam int A_20 = 10;
    localparam int A_21 = 11;
    localparam int A_UPPER = 12;
    localparam logic [12:0] ADDR_START = 13'h0fff;

    // micro_data_register positions
    localparam int MDR_W = 22;
    localparam int NSI_LO = 10;
    localparam int NSI_W = 12;
    localparam int MDR_16 = 16;
    localparam int MDR_17 = 17;

    // Control-store word slices
    localparam int WORD_W = 60;
    localparam int SLICE_A_LO = 0;
    localparam int SLICE_A_W = 16;
    localparam int SLICE_B_LO = 16;
    localparam int SLICE_C_LO = 38;
    localparam int SLICE_BC_W = 22;

    // Sense strobe positions
    localparam int STROBE_A = 0;
    localparam int STROBE_B = 1;
    localparam int STROBE_C = 2;

    // Register map
    localparam logic [3:0] REG_CONTROL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h1;
    localparam logic [3:0] REG_DATA = 4'h2;
    localparam int CTRL_RUN = 0;
    localparam int CTRL_START = 1;
    localparam logic CONTROL_RUN_RESET = 1'b1;

    typedef enum {RING_S1, RING_S2, RING_S3} msa_ring_t;

    typedef struct packed {
        logic [12:0] spare;
        logic core_busy;
        logic advance;
        logic [1:0] ring_second;
        logic [1:0] ring_first;
        logic [12:0] address;
    } msa_status_t;

    typedef struct packed {
        logic [31:0] gate;
        logic [63:0] driver;
        logic [2:0] strobe;
    } msa_select_t;

endpackage

// ==== hw/msa_sequencer.sv ====
// Microstore address register, matrix decode, sense strobes and timing rings
`timescale 1ns/1ps

module msa_sequencer
    import msa_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic start_reset_pin,
    input wire logic fetch_store,
    input wire logic fetch_store_short,
    input wire logic [WORD_W-1:0] store_word,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic [31:0] gate_line,
    output logic [63:0] driver_line,
    output logic [2:0] sense_strobe,
    output logic [MDR_W-1:0] micro_data_register,
    output logic [12:0] micro_address_register,
    output logic early_clock,
    output logic late_clock,
    output logic advance,
    output logic core_start,
    output logic dummy_cycle
);

    function automatic logic [7:0] msa_onehot8(input logic [2:0] sel);
        msa_onehot8 = 8'h01 << sel;
    endfunction

    function automatic logic [2:0] msa_strobe_of(input logic b16,
                                                 input logic b17);
        logic [2:0] s;
        s = 3'h0;
        if (!b16) begin
            s[STROBE_A] = 1'b1;
        end else if (!b17) begin
            s[STROBE_B] = 1'b1;
        end else begin
            s[STROBE_C] = 1'b1;
        end
        return s;
    endfunction

    logic start_meta;
    logic start_sync;
    logic run;
    logic soft_start;
    logic [3:0] phase;
    msa_ring_t ring_first;
    msa_ring_t ring_second;

    logic early_now;
    logic late_now;
    logic drv_window;
    logic next_advance;
    logic start_now;
    logic [3:0] gate_pre1;
    logic [7:0] gate_pre2;
    logic [7:0] drv_pre1;
    logic [7:0] drv_pre2;
    msa_select_t next_sel;
    msa_status_t status;

    // Pin level is only read after the second flop
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            start_meta <= 1'b0;
            start_sync <= 1'b0;
        end else begin
            start_meta <= start_reset_pin;
            start_sync <= start_meta;
        end
    end

    assign start_now = start_sync || soft_start;

    // Cycle phase; stopping only takes effect at a cycle boundary
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            phase <= PH_EARLY;
        end else if (phase == PH_LAST) begin
            phase <= PH_EARLY;
        end else if (phase != PH_EARLY || run) begin
            phase <= phase + 4'h1;
        end
    end

    assign early_now = run && (phase == PH_EARLY);
    assign late_now = (phase == PH_LATE);
    assign drv_window = (phase >= PH_DRV_ON) && (phase < PH_DRV_OFF);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            early_clock <= 1'b0;
            late_clock <= 1'b0;
        end else begin
            early_clock <= early_now;
            late_clock <= late_now;
        end
    end

    // Second ring lags the first by nine of the twelve clocks in a cycle, so advance is judged on it
    always_comb begin
        case (ring_second)
            RING_S1: next_advance = !fetch_store || fetch_store_short;
            RING_S2: next_advance = 1'b1;
            RING_S3: next_advance = !fetch_store;
            default: next_advance = 1'b1;
        endcase
    end

    // First ring, stepped by the early clock
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ring_first <= RING_S1;
        end else if (start_now) begin
            ring_first <= RING_S1;
        end else if (early_now) begin
            case (ring_first)
                RING_S1: ring_first <= fetch_store ? RING_S2 : RING_S1;
                RING_S2: ring_first <= RING_S3;
                RING_S3: ring_first <= RING_S1;
                default: ring_first <= RING_S1;
            endcase
        end
    end

    // Second ring follows the first at the late clock
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ring_second <= RING_S1;
        end else if (start_now) begin
            ring_second <= RING_S1;
        end else if (late_now) begin
            ring_second <= ring_first;
        end
    end

    // Held address makes the array re-read the same instruction
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            micro_address_register <= ADDR_START;
        end else if (start_now) begin
            micro_address_register[A_UPPER-1:0] <=
                ADDR_START[A_UPPER-1:0];
        end else if (early_now && next_advance) begin
            micro_address_register[A_UPPER-1:0] <=
                micro_data_register[NSI_LO +: NSI_W];
            if (!micro_data_register[MDR_16]) begin
                micro_address_register[A_UPPER] <=
                    !micro_data_register[MDR_17];
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            advance <= 1'b1;
            dummy_cycle <= 1'b0;
            core_start <= 1'b0;
        end else begin
            core_start <= early_now && !start_now && fetch_store
                && (ring_first == RING_S1);
            if (start_now) begin
                advance <= 1'b1;
                dummy_cycle <= 1'b0;
            end else if (early_now) begin
                advance <= next_advance;
                dummy_cycle <= !next_advance;
            end
        end
    end

    // Predecoders then final decoders; upper bit and 12 name the module
    assign gate_pre1 = 4'(msa_onehot8({1'b0,
        micro_address_register[A_UPPER],
        micro_address_register[A_12]}));
    assign gate_pre2 = msa_onehot8({micro_address_register[A_10],
        micro_address_register[A_11],
        micro_address_register[A_13]});
    assign drv_pre1 = msa_onehot8({micro_address_register[A_14],
        micro_address_register[A_15],
        micro_address_register[A_18]});
    assign drv_pre2 = msa_onehot8({micro_address_register[A_19],
        micro_address_register[A_20],
        micro_address_register[A_21]});

    always_comb begin
        next_sel = '0;
        for (int g = 0; g < 4; g++) begin
            for (int h = 0; h < 8; h++) begin
                next_sel.gate[g*8+h] = gate_pre1[g] && gate_pre2[h];
            end
        end
        for (int d = 0; d < 8; d++) begin
            for (int e = 0; e < 8; e++) begin
                next_sel.driver[d*8+e] = drv_window
                    && drv_pre1[d] && drv_pre2[e];
            end
        end
        if (phase == PH_SENSE) begin
            next_sel.strobe = msa_strobe_of(
                micro_address_register[A_16],
                micro_address_register[A_17]);
        end
        if (!drv_window) begin
            next_sel.gate = '0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            gate_line <= '0;
            driver_line <= '0;
            sense_strobe <= '0;
        end else begin
            gate_line <= next_sel.gate;
            driver_line <= next_sel.driver;
            sense_strobe <= next_sel.strobe;
        end
    end

    // Only the strobed third of the word lands in the data register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            micro_data_register <= '0;
        end else if (sense_strobe[STROBE_A]) begin
            micro_data_register <= MDR_W'(
                store_word[SLICE_A_LO +: SLICE_A_W]);
        end else if (sense_strobe[STROBE_B]) begin
            micro_data_register <=
                store_word[SLICE_B_LO +: SLICE_BC_W];
        end else if (sense_strobe[STROBE_C]) begin
            micro_data_register <=
                store_word[SLICE_C_LO +: SLICE_BC_W];
        end
    end

    // Control register: run enable and self-clearing start reset
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            run <= CONTROL_RUN_RESET;
            soft_start <= 1'b0;
        end else begin
            soft_start <= reg_wr && (reg_addr == REG_CONTROL)
                && reg_wdata[CTRL_START];
            if (reg_wr && reg_addr == REG_CONTROL) begin
                run <= reg_wdata[CTRL_RUN];
            end
        end
    end

    always_comb begin
        status = '0;
        status.address = micro_address_register;
        status.ring_first = 2'(ring_first);
        status.ring_second = 2'(ring_second);
        status.advance = advance;
        status.core_busy = (ring_first != RING_S1);
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                REG_CONTROL: reg_rdata <= 32'({1'b0, run});
                REG_STATUS: reg_rdata <= status;
                REG_DATA: reg_rdata <= 32'(micro_data_register);
                default: reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

endmodule // msa_sequencer

// ==== sim/msa_sequencer_props.sv ====
// Concurrent checks on the sequencer's select, strobe and capture outputs
`timescale 1ns/1ps
module msa_sequencer_props
    import msa_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [WORD_W-1:0] store_word,
    input wire logic [31:0] gate_line,
    input wire logic [63:0] driver_line,
    input wire logic [2:0] sense_strobe,
    input wire logic [MDR_W-1:0] micro_data_register,
    input wire logic [12:0] micro_address_register,
    input wire logic early_clock,
    input wire logic late_clock
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic [12:0] a;
    logic [21:0] pick;
    assign a = micro_address_register;
    assign pick = sense_strobe[STROBE_C] ? store_word[59:38] :
        sense_strobe[STROBE_B] ? store_word[37:16] : {6'h0, store_word[15:0]};
    property p_gate_hot;
        |driver_line |-> $onehot(gate_line);
    endproperty
    a_gate_hot: assert property (p_gate_hot)
        else $error("gate lines not one-hot");
    property p_pair;
        |gate_line |-> $onehot(driver_line);
    endproperty
    a_pair: assert property (p_pair)
        else $error("gate without a single driver");
    property p_gate_dec;
        |gate_line |-> gate_line == (32'h1 << {a[12], a[2], a[0], a[1], a[3]});
    endproperty
    a_gate_dec: assert property (p_gate_dec)
        else $error("wrong gate line");
    property p_drv_dec;
        |driver_line |-> driver_line ==
            (64'h1 << {a[4], a[5], a[8], a[9], a[10], a[11]});
    endproperty
    a_drv_dec: assert property (p_drv_dec)
        else $error("wrong driver line");
    property p_window;
        $rose(|driver_line) |-> (|driver_line) [*6] ##1 !(|driver_line);
    endproperty
    a_window: assert property (p_window)
        else $error("driver window not six clocks");
    property p_strobe_sel;
        |sense_strobe |-> sense_strobe == (a[6] ? (a[7] ? 3'h4 : 3'h2) : 3'h1);
    endproperty
    a_strobe_sel: assert property (p_strobe_sel)
        else $error("wrong sense strobe");
    property p_strobe_drv;
        |sense_strobe |-> |driver_line;
    endproperty
    a_strobe_drv: assert property (p_strobe_drv)
        else $error("sense strobe outside drive window");
    property p_capture;
        |sense_strobe |=> micro_data_register == $past(pick);
    endproperty
    a_capture: assert property (p_capture)
        else $error("wrong slice captured");
    property p_late;
        early_clock |-> ##9 late_clock;
    endproperty
    a_late: assert property (p_late)
        else $error("late clock not nine clocks after early");
endmodule // msa_sequencer_props

bind msa_sequencer msa_sequencer_props u_props (
    .ref_clk(ref_clk), .rst(rst), .store_word(store_word),
    .gate_line(gate_line), .driver_line(driver_line),
    .sense_strobe(sense_strobe), .micro_data_register(micro_data_register),
    .micro_address_register(micro_address_register),
    .early_clock(early_clock), .late_clock(late_clock)
);

// ==== sim/msa_store_model.sv ====
// Control store array model answering the sequencer's word lines
`timescale 1ns/1ps
module msa_store_model
    import msa_pkg::*;
(
    input wire logic [31:0] gate_line,
    input wire logic [63:0] driver_line,
    input wire logic [MDR_W-1:0] micro_data_register,
    output logic [WORD_W-1:0] store_word,
    output logic fetch_store,
    output logic fetch_store_short
);
    logic [WORD_W-1:0] prog [2048];
    logic [10:0] idx;
    always_comb begin
        idx = 11'h0;
        for (int i = 0; i < 64; i++) begin
            if (gate_line[i & 31] && i < 32) idx[10:6] = 5'(i);
            if (driver_line[i]) idx[5:0] = 6'(i);
        end
    end
    // Undriven word shows its inverse, so a late sample cannot pass
    assign store_word = (|driver_line) ? prog[idx] : ~prog[idx];
    // Op decode stand-in: bit 1 fetch/store, bit 2 short form
    assign fetch_store = micro_data_register[1];
    assign fetch_store_short = micro_data_register[2];
endmodule // msa_store_model

// ==== sim/test_msa_sequencer.sv ====
// Self-checking bench for the microstore address sequencer
`timescale 1ns/1ps
module test_msa_sequencer
    import msa_pkg::*;
;
    logic ref_clk = 0, rst = 1, start_reset_pin = 0, reg_wr = 0, reg_rd = 0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, gate_line, d;
    logic [63:0] driver_line;
    logic [2:0] sense_strobe;
    logic [MDR_W-1:0] micro_data_register;
    logic [12:0] micro_address_register;
    logic [WORD_W-1:0] store_word;
    logic early_clock, late_clock, advance, core_start, dummy_cycle, hold;
    logic fetch_store, fetch_store_short, watch = 0, saw_core = 0;
    logic [31:0] seed = 32'h77f8;
    logic [21:0] last_m;
    logic [36:0] e;
    logic [36:0] exp_q [$];
    bit [2:0] used [2048];
    int fail_count = 0, check_count = 0, cycles = 0;
    msa_sequencer dut (.ref_clk, .rst, .start_reset_pin, .fetch_store,
        .fetch_store_short, .store_word, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .gate_line, .driver_line, .sense_strobe,
        .micro_data_register, .micro_address_register, .early_clock,
        .late_clock, .advance, .core_start, .dummy_cycle);
    msa_store_model u_store (.gate_line, .driver_line, .micro_data_register,
        .store_word, .fetch_store, .fetch_store_short);
    initial forever #25 ref_clk = ~ref_clk;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input logic [63:0] got, exp, input string what);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    function automatic logic [10:0] widx(input logic [12:0] a);
        return {a[12], a[2], a[0], a[1], a[3], a[4], a[5], a[8], a[9], a[10],
            a[11]};
    endfunction
    // Fills a slot on first visit, so loops in the random chain stay sound
    function automatic logic [21:0] instr(input logic [12:0] a);
        logic [10:0] w;
        logic [31:0] r;
        int s;
        w = widx(a);
        s = a[6] ? (a[7] ? 2 : 1) : 0;
        r = rnd();
        r[2] = r[2] & r[3];
        if (!used[w][s]) begin
            used[w][s] = 1'b1;
            if (s == 0) u_store.prog[w][15:0] = r[15:0];
            else if (s == 1) u_store.prog[w][37:16] = r[21:0];
            else u_store.prog[w][59:38] = r[21:0];
        end
        if (s == 0) return {6'h0, u_store.prog[w][15:0]};
        return s == 1 ? u_store.prog[w][37:16] : u_store.prog[w][59:38];
    endfunction
    task automatic build(input logic [12:0] a);
        logic [21:0] m;
        logic [1:0] ring;
        logic adv;
        logic core;
        ring = 2'h0;
        m = instr(a);
        repeat (60) begin
            adv = ring == 2'h0 ? !(m[1] && !m[2]) : ring == 2'h1 ? 1'b1 : !m[1];
            core = (ring == 2'h0) && m[1];
            ring = ring == 2'h0 ? {1'b0, m[1]} : ring == 2'h1 ? 2'h2 : 2'h0;
            if (adv) a = {m[16] ? a[12] : !m[17], m[21:10]};
            exp_q.push_back({core, m, !adv, a});
            m = instr(a);
        end
        last_m = m;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
        v = reg_rdata;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            $display("MISMATCH at %0t: run did not finish", $time);
            tally_and_finish();
        end
        if (core_start) saw_core = 1'b1;
        if (watch && sense_strobe != 3'h0 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            check(micro_address_register, e[12:0], "addr");
            check(dummy_cycle, e[13], "dummy");
            check(advance, !e[13], "advance");
            check(micro_data_register, e[35:14], "mdr");
            check(saw_core, e[36], "core start");
            saw_core = 1'b0;
        end
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        wait (sense_strobe != 3'h0);
        build(micro_address_register);
        repeat (2) @(negedge ref_clk);
        saw_core = 1'b0;
        watch = 1'b1;
        wait (exp_q.size() == 0);
        @(negedge ref_clk);
        watch = 1'b0;
        $display("microprogram walk done");
        wr(REG_CONTROL, 32'h0);
        repeat (30) @(posedge ref_clk);
        hold = micro_address_register[12];
        start_reset_pin <= 1'b1;
        repeat (3) @(posedge ref_clk);
        start_reset_pin <= 1'b0;
        repeat (3) @(posedge ref_clk);
        check(micro_address_register, {hold, 12'hfff}, "start");
        rd(REG_STATUS, d);
        check(d[17:0], {1'b1, 4'h0, hold, 12'hfff}, "status");
        rd(REG_CONTROL, d);
        check(d, 32'h0, "control");
        rd(4'hf, d);
        check(d, 32'h0, "unmapped");
        rd(REG_DATA, d);
        check(d, {10'h0, last_m}, "data");
        $display("register and start reset test done");
        tally_and_finish();
    end
endmodule // test_msa_sequencer
